// [include/hle_pkg.sv]
`default_nettype none
package hle_pkg;
    // Octet codes seen on the serial side
    localparam logic [7:0] HLE_FLAG = 8'h7E;
    localparam logic [7:0] HLE_ESC = 8'h7D;
    localparam logic [7:0] HLE_ESC_XOR = 8'h20;
    localparam logic [7:0] HLE_RATE_ADAPT = 8'hDD;
    localparam logic [7:0] HLE_HDLC_ABORT = 8'hFF;
    // Bit stuffing thresholds (ones already seen)
    localparam logic [2:0] HLE_STUFF_ONES = 3'h5;
    localparam logic [2:0] HLE_ABORT_ONES = 3'h6;
    // Header and FCS lengths in octets
    localparam logic [1:0] HLE_HDR_LAST = 2'h3;
    localparam logic [11:0] HLE_HDR_LEN = 12'h004;
    localparam logic [2:0] HLE_FCS16_LEN = 3'h2;
    localparam logic [2:0] HLE_FCS32_LEN = 3'h4;
    // Bounds of the programmable packet size
    localparam logic [10:0] HLE_LEN_MIN = 11'h040;
    localparam logic [10:0] HLE_LEN_MAX = 11'h7E0;
    // Reflected CRC polynomials, seeds and good residues
    localparam logic [31:0] HLE_CRC16_POLY = 32'h0000_8408;
    localparam logic [31:0] HLE_CRC32_POLY = 32'hEDB8_8320;
    localparam logic [31:0] HLE_CRC16_INIT = 32'h0000_FFFF;
    localparam logic [31:0] HLE_CRC32_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] HLE_CRC16_GOOD = 32'h0000_F0B8;
    localparam logic [31:0] HLE_CRC32_GOOD = 32'hDEBB_20E3;
    // Scrambler span and transmit buffer depth
    localparam int HLE_SCR_LEN = 43;
    localparam int HLE_FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        T_FILL, T_HDR, T_DATA, T_FCS, T_END
    } hle_tx_state_t;

    typedef struct packed {
        logic x86;
        logic scr_en;
        logic tx_fcs_en;
        logic rx_fcs_en;
        logic fcs32;
        logic fcs_corrupt;
        logic [7:0] fill;
        logic [7:0] tx_addr;
        logic [7:0] tx_ctrl;
        logic [15:0] tx_sapi;
        logic [7:0] rx_addr;
        logic [7:0] rx_ctrl;
        logic [15:0] rx_sapi;
        logic [10:0] len_min;
        logic [10:0] len_max;
    } hle_cfg_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } hle_pkt_t;

    typedef struct packed {
        logic valid;
        logic eop;
        logic bad;
        logic [7:0] data;
    } hle_rx_t;

    // One octet through a reflected CRC, LSB first
    function automatic logic [31:0] hle_crc_byte(input logic [31:0] c,
        input logic [7:0] d, input logic wide);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ (wide ? HLE_CRC32_POLY : HLE_CRC16_POLY);
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    // Self-synchronising x^43+1, returns {state, octet}
    function automatic logic [50:0] hle_scr_byte(input logic [42:0] s,
        input logic [7:0] d, input logic descr);
        logic [42:0] t;
        logic [7:0] o;
        t = s;
        o = 8'h00;
        for (int i = 0; i < 8; i++) begin
            o[i] = d[i] ^ t[HLE_SCR_LEN-1];
            t = {t[41:0], descr ? d[i] : o[i]};
        end
        return {t, o};
    endfunction

    // Address, control and two SAPI octets in wire order
    function automatic logic [7:0] hle_hdr(input logic [7:0] a,
        input logic [7:0] c, input logic [15:0] sp, input logic [1:0] i);
        case (i)
            2'h0: return a;
            2'h1: return c;
            2'h2: return sp[15:8];
            default: return sp[7:0];
        endcase
    endfunction
endpackage
`default_nettype wire

// [verilog/hle_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module hle_fifo
    import hle_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = HLE_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic room;
    } hle_fifo_st_t;

    hle_fifo_st_t q;
    hle_fifo_st_t next_q;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pull;

    function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Handshakes; ready is a stored flag so the source sees a clean level
    assign push = i_in_valid && q.room;
    assign pull = i_out_ready && (q.cnt != '0);
    assign o_in_ready = q.room;
    assign o_out_valid = (q.cnt != '0);
    assign o_out_data = mem[q.rp];

    // Pointer and fill bookkeeping
    always_comb begin
        next_q = q;
        if (push) begin
            next_q.wp = wrap(q.wp);
        end
        if (pull) begin
            next_q.rp = wrap(q.rp);
        end
        next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pull);
        next_q.room = (next_q.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{wp: '0, rp: '0, cnt: '0, room: 1'b1};
        end else if (i_ce) begin
            q <= next_q;
        end
    end

    // Storage has no reset; contents are only read below the fill count
    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[q.wp] <= i_in_data;
        end
    end
endmodule // hle_fifo
`default_nettype wire

// [verilog/hle_encap.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - X.86 transmit sends a scrambled octet 7E as escape pair 7D 5E.
// - X.86 transmit sends a scrambled octet 7D as escape pair 7D 5D.
// - X.86 receive drops rate adaptation pair 7D DD entirely.
// - X.86 receive turns escape pair 7D 5E back into 7E.
// - X.86 receive turns escape pair 7D 5D back into 7D.
// - X.86 receive discards the whole packet on abort 7D 7E.
// - X.86 scrambles transmit and descrambles receive with x^43+1.
// - X.86 address and control are programmable per direction.
// - X.86 two-octet SAPI is programmable per direction.
// - HDLC packet size limits programmable between 64 and 2016 octets.
// - HDLC FCS insertion and extraction switchable, FCS type selectable.
// - Transmit can corrupt outgoing FCS on command for testing.
// - Receive counts bad-FCS packets and aborted packets separately.
// - Programmable fill pattern is sent between transmitted frames.
// - HDLC x^43+1 scrambling and descrambling selectable by software.
module hle_encap
    import hle_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire hle_cfg_t i_cfg,
    input wire hle_pkt_t i_tx,
    output logic o_tx_ready,
    input wire logic i_tx_bit_en,
    output logic o_tx_bit,
    input wire logic i_rx_bit_en,
    input wire logic i_rx_bit,
    output hle_rx_t o_rx,
    output logic [CNT_W-1:0] o_bad_fcs_cnt,
    output logic [CNT_W-1:0] o_abort_cnt
);
    typedef struct packed {
        hle_tx_state_t tst;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic sstuff;
        logic [2:0] ones;
        logic tx_bit;
        logic esc;
        logic [7:0] esc_b;
        logic [1:0] idx;
        logic [31:0] tcrc;
        logic [42:0] tscr;
        logic [7:0] rsr;
        logic [2:0] rones;
        logic [7:0] rbyte;
        logic [2:0] rbits;
        logic rsync;
        logic resc;
        logic hbad;
        logic [42:0] rscr;
        logic [31:0] rcrc;
        logic [11:0] rlen;
        logic [3:0][7:0] dl;
        logic [2:0] dcnt;
        hle_rx_t rx;
        logic [CNT_W-1:0] nbad;
        logic [CNT_W-1:0] nabt;
    } hle_core_t;

    hle_core_t q;
    hle_core_t next_q;
    logic fifo_v;
    logic [8:0] fifo_d;
    logic pop;

    // Packets wait here; a full buffer pushes back on the MAC side
    hle_fifo #(
        .WIDTH(9),
        .DEPTH(HLE_FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_in_valid(i_tx.valid),
        .i_in_data({i_tx.last, i_tx.data}),
        .o_in_ready(o_tx_ready),
        .o_out_valid(fifo_v),
        .o_out_data(fifo_d),
        .i_out_ready(pop)
    );

    assign o_tx_bit = q.tx_bit;
    assign o_rx = q.rx;
    assign o_bad_fcs_cnt = q.nbad;
    assign o_abort_cnt = q.nabt;

    // Transmit octet source, bit serialiser, receive deframer
    always_comb begin
        logic x86, scr, wide, tfcs, rfcs, take, cont, crc_it, vok, good, ok;
        logic [7:0] pb, nb, b, rs, v, d;
        logic nstuff, s;
        logic [50:0] sr;
        logic [31:0] fcsv;
        logic [2:0] nfcs, keep;
        logic [10:0] lmin, lmax;
        next_q = q;
        x86 = i_cfg.x86;
        scr = x86 | i_cfg.scr_en;
        wide = x86 | i_cfg.fcs32;
        tfcs = x86 | i_cfg.tx_fcs_en;
        rfcs = x86 | i_cfg.rx_fcs_en;
        nfcs = wide ? HLE_FCS32_LEN : HLE_FCS16_LEN;
        keep = rfcs ? nfcs : 3'h0;
        fcsv = ~q.tcrc ^ {31'h0000_0000, i_cfg.fcs_corrupt};
        lmin = (i_cfg.len_min < HLE_LEN_MIN) ? HLE_LEN_MIN : i_cfg.len_min;
        lmax = (i_cfg.len_max > HLE_LEN_MAX) ? HLE_LEN_MAX : i_cfg.len_max;
        take = i_tx_bit_en && q.cnt == 4'h0
            && !(q.sstuff && q.ones == HLE_STUFF_ONES);
        pop = 1'b0;
        cont = 1'b0;
        crc_it = 1'b0;
        pb = 8'h00;
        nb = i_cfg.fill;
        nstuff = 1'b0;
        b = 8'h00;
        s = 1'b0;
        sr = '0;
        rs = 8'h00;
        v = 8'h00;
        d = 8'h00;
        vok = 1'b0;
        good = 1'b0;
        ok = 1'b0;
        next_q.rx.valid = 1'b0;
        next_q.rx.eop = 1'b0;
        next_q.rx.bad = 1'b0;

        // Next octet is chosen only when the serialiser asks for one
        if (take && q.esc) begin
            nb = q.esc_b;
            next_q.esc = 1'b0;
        end else if (take) begin
            case (q.tst)
                T_FILL: begin
                    if (fifo_v) begin
                        nb = HLE_FLAG;
                        next_q.tst = x86 ? T_HDR : T_DATA;
                        next_q.idx = 2'h0;
                        next_q.tcrc = wide ? HLE_CRC32_INIT : HLE_CRC16_INIT;
                    end
                end
                T_HDR: begin
                    cont = 1'b1;
                    crc_it = 1'b1;
                    pb = hle_hdr(i_cfg.tx_addr, i_cfg.tx_ctrl, i_cfg.tx_sapi,
                        q.idx);
                    next_q.idx = q.idx + 2'h1;
                    if (q.idx == HLE_HDR_LAST) begin
                        next_q.tst = T_DATA;
                    end
                end
                T_DATA: begin
                    if (fifo_v) begin
                        cont = 1'b1;
                        crc_it = 1'b1;
                        pb = fifo_d[7:0];
                        pop = 1'b1;
                        if (fifo_d[8]) begin
                            next_q.tst = tfcs ? T_FCS : T_END;
                            next_q.idx = 2'h0;
                        end
                    end else begin
                        // Underrun: the frame is aborted, not stretched
                        nb = x86 ? HLE_ESC : HLE_HDLC_ABORT;
                        next_q.tst = T_END;
                    end
                end
                T_FCS: begin
                    cont = 1'b1;
                    pb = fcsv[8*q.idx +: 8];
                    next_q.idx = q.idx + 2'h1;
                    if ({1'b0, q.idx} == nfcs - 3'h1) begin
                        next_q.tst = T_END;
                    end
                end
                default: begin
                    nb = HLE_FLAG;
                    next_q.tst = T_FILL;
                end
            endcase
            if (cont) begin
                sr = hle_scr_byte(q.tscr, pb, 1'b0);
                if (scr) begin
                    next_q.tscr = sr[50:8];
                end
                nb = scr ? sr[7:0] : pb;
                nstuff = !x86;
                if (x86 && (nb == HLE_FLAG || nb == HLE_ESC)) begin
                    next_q.esc = 1'b1;
                    next_q.esc_b = nb ^ HLE_ESC_XOR;
                    nb = HLE_ESC;
                end
                if (crc_it) begin
                    next_q.tcrc = hle_crc_byte(q.tcrc, pb, wide);
                end
            end
        end

        // Serialiser, LSB first; a stuffed zero may trail the last octet
        if (i_tx_bit_en) begin
            if (q.sstuff && q.ones == HLE_STUFF_ONES) begin
                next_q.tx_bit = 1'b0;
                next_q.ones = 3'h0;
            end else begin
                b = (q.cnt == 4'h0) ? nb : q.sh;
                s = (q.cnt == 4'h0) ? nstuff : q.sstuff;
                next_q.tx_bit = b[0];
                next_q.sh = {1'b0, b[7:1]};
                next_q.cnt = ((q.cnt == 4'h0) ? 4'h8 : q.cnt) - 4'h1;
                next_q.sstuff = s;
                next_q.ones = (s && b[0]) ? q.ones + 3'h1 : 3'h0;
            end
        end

        // Receive bit level: flag hunt, abort, destuffing, octet build
        if (i_rx_bit_en) begin
            rs = {i_rx_bit, q.rsr[7:1]};
            next_q.rsr = rs;
            next_q.rones = !i_rx_bit ? 3'h0
                : (q.rones == 3'h7) ? 3'h7 : q.rones + 3'h1;
            // X.86 is octet framed: once in sync only aligned flags count
            if (rs == HLE_FLAG && (!x86 || !q.rsync || q.rbits == 3'h7)) begin
                if (q.rsync && q.resc) begin
                    next_q.nabt = q.nabt + 1'b1;
                    next_q.rx.eop = 1'b1;
                    next_q.rx.bad = 1'b1;
                end else if (q.rsync && q.rlen != 12'h000) begin
                    ok = !rfcs
                        || q.rcrc == (wide ? HLE_CRC32_GOOD : HLE_CRC16_GOOD);
                    good = ok && !q.hbad && q.rbits == 3'h7 && (x86
                        || (q.rlen >= {1'b0, lmin} && q.rlen <= {1'b0, lmax}));
                    if (!ok) begin
                        next_q.nbad = q.nbad + 1'b1;
                    end
                    next_q.rx.eop = 1'b1;
                    next_q.rx.bad = !good;
                end
                next_q.rsync = 1'b1;
                next_q.resc = 1'b0;
                next_q.hbad = 1'b0;
                next_q.rlen = 12'h000;
                next_q.dcnt = 3'h0;
                next_q.rbits = 3'h0;
                next_q.rcrc = wide ? HLE_CRC32_INIT : HLE_CRC16_INIT;
            end else if (!x86 && i_rx_bit && q.rones == HLE_ABORT_ONES) begin
                // Seven ones: abort, then hunt for the next flag
                if (q.rsync && q.rlen != 12'h000) begin
                    next_q.nabt = q.nabt + 1'b1;
                    next_q.rx.eop = 1'b1;
                    next_q.rx.bad = 1'b1;
                end
                next_q.rsync = 1'b0;
            end else if (x86 || i_rx_bit || q.rones != HLE_STUFF_ONES) begin
                next_q.rbyte = {i_rx_bit, q.rbyte[7:1]};
                next_q.rbits = q.rbits + 3'h1;
                vok = q.rsync && q.rbits == 3'h7;
            end
        end

        // Receive octet level: transparency, descramble, CRC, header
        if (vok) begin
            v = next_q.rbyte;
            if (x86 && q.resc) begin
                next_q.resc = 1'b0;
                vok = (v != HLE_RATE_ADAPT);
                v = v ^ HLE_ESC_XOR;
            end else if (x86 && v == HLE_ESC) begin
                next_q.resc = 1'b1;
                vok = 1'b0;
            end
        end
        if (vok) begin
            sr = hle_scr_byte(q.rscr, v, 1'b1);
            if (scr) begin
                next_q.rscr = sr[50:8];
            end
            d = scr ? sr[7:0] : v;
            next_q.rcrc = hle_crc_byte(q.rcrc, d, wide);
            if (q.rlen != 12'hFFF) begin
                next_q.rlen = q.rlen + 12'h001;
            end
            if (x86 && q.rlen < HLE_HDR_LEN) begin
                if (d != hle_hdr(i_cfg.rx_addr, i_cfg.rx_ctrl,
                    i_cfg.rx_sapi, q.rlen[1:0])) begin
                    next_q.hbad = 1'b1;
                end
            end else if (keep == 3'h0) begin
                next_q.rx.valid = 1'b1;
                next_q.rx.data = d;
            end else begin
                if (q.dcnt == keep) begin
                    next_q.rx.valid = 1'b1;
                    next_q.rx.data = q.dl[2'(keep - 3'h1)];
                end else begin
                    next_q.dcnt = q.dcnt + 3'h1;
                end
                next_q.dl = {q.dl[2:0], d};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else if (i_ce) begin
            q <= next_q;
        end
    end
endmodule // hle_encap
`default_nettype wire

// [testbench/hle_encap_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module hle_encap_chk
    import hle_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire hle_cfg_t i_cfg,
    input wire hle_pkt_t i_tx,
    input wire logic o_tx_ready,
    input wire logic i_tx_bit_en,
    input wire logic o_tx_bit,
    input wire logic i_rx_bit_en,
    input wire logic i_rx_bit,
    input wire hle_rx_t o_rx,
    input wire logic [CNT_W-1:0] o_bad_fcs_cnt,
    input wire logic [CNT_W-1:0] o_abort_cnt
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_TX_BIT_HOLD: assert property (
        !(i_tx_bit_en && i_ce) |=> $stable(o_tx_bit))
        else $error("tx bit moved without a bit enable");
    AST_RX_VALID_CAUSE: assert property (
        o_rx.valid && $past(i_ce) |-> $past(i_rx_bit_en))
        else $error("rx octet without a receive strobe");
    AST_RX_EOP_CAUSE: assert property (
        o_rx.eop && $past(i_ce) |-> $past(i_rx_bit_en) && !o_rx.valid)
        else $error("frame end without strobe or with data");
    AST_RX_BAD_EOP: assert property (
        o_rx.bad |-> o_rx.eop)
        else $error("discard mark outside a frame end");
    AST_BAD_FCS_STEP: assert property (
        o_bad_fcs_cnt != $past(o_bad_fcs_cnt)
        |-> o_bad_fcs_cnt == $past(o_bad_fcs_cnt) + CNT_W'(1))
        else $error("bad check counter jumped");
    AST_ABORT_STEP: assert property (
        o_abort_cnt != $past(o_abort_cnt)
        |-> o_abort_cnt == $past(o_abort_cnt) + CNT_W'(1))
        else $error("abort counter jumped");
    AST_CE_FREEZE: assert property (
        !i_ce |=> $stable(o_bad_fcs_cnt) && $stable(o_abort_cnt)
        && $stable(o_tx_bit) && $stable(o_tx_ready))
        else $error("state moved while clock enable low");
    // Queue can only fill after a push
    AST_READY_FALL: assert property (
        $fell(o_tx_ready) |-> $past(i_tx.valid && i_ce))
        else $error("ready fell without a push");
endmodule // hle_encap_chk

bind hle_encap hle_encap_chk #(.CNT_W(CNT_W)) hle_encap_chk_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_cfg(i_cfg),
    .i_tx(i_tx), .o_tx_ready(o_tx_ready), .i_tx_bit_en(i_tx_bit_en),
    .o_tx_bit(o_tx_bit), .i_rx_bit_en(i_rx_bit_en), .i_rx_bit(i_rx_bit),
    .o_rx(o_rx), .o_bad_fcs_cnt(o_bad_fcs_cnt), .o_abort_cnt(o_abort_cnt));
`default_nettype wire

// [testbench/hle_serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module hle_serial_peer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire logic i_tx_bit,
    input wire logic i_inj_en,
    input wire logic i_inj_bit,
    output logic o_bit_en,
    output logic o_rx_bit
);
    logic [1:0] cnt;

    // Free bit clock of the backplane, strobe every second cycle; slow mode halves that so the queue fills
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
    assign o_bit_en = i_slow ? (cnt == 2'h3) : cnt[0];
    // Line loops back unless raw bits are injected
    assign o_rx_bit = i_inj_en ? i_inj_bit : i_tx_bit;
endmodule // hle_serial_peer
`default_nettype wire

// [testbench/hle_encap_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module hle_encap_bench;
    import hle_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    hle_cfg_t cfg;
    hle_pkt_t tx;
    hle_rx_t rx;
    logic tx_ready, tx_bit, bit_en, rx_bit, slow, inj_en, inj_bit;
    logic [15:0] bad_cnt, abort_cnt;
    int mismatches = 0;
    int cmp_count = 0;
    int seed = 32'h4952;
    int eops = 0;
    logic last_bad = 1'b0;
    logic saw_full = 1'b0;
    logic [7:0] pl[$];
    logic [7:0] rxq[$];

    always #2 i_clk = ~i_clk;

    hle_encap hle_encap_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_ce(i_ce), .i_cfg(cfg), .i_tx(tx), .o_tx_ready(tx_ready),
        .i_tx_bit_en(bit_en), .o_tx_bit(tx_bit), .i_rx_bit_en(bit_en),
        .i_rx_bit(rx_bit), .o_rx(rx), .o_bad_fcs_cnt(bad_cnt),
        .o_abort_cnt(abort_cnt));
    hle_serial_peer hle_serial_peer_inst (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_slow(slow), .i_tx_bit(tx_bit),
        .i_inj_en(inj_en), .i_inj_bit(inj_bit), .o_bit_en(bit_en),
        .o_rx_bit(rx_bit));

    // Collect octets and frame ends; pulses last one cycle
    always @(posedge i_clk) begin
        if (rx.valid === 1'b1) rxq.push_back(rx.data);
        if (rx.eop === 1'b1) begin
            last_bad = rx.bad;
            eops++;
        end
        if (tx_ready === 1'b0) saw_full = 1'b1;
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic note(input logic ok, input string m);
        cmp_count++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic hang(input string m);
        note(1'b0, m);
        end_of_test();
    endtask
    task automatic cmp_oct(input logic [7:0] g, input logic [7:0] e);
        note(g === e, "payload octet differs");
    endtask
    task automatic cmp_flag(input logic g, input logic e, input string m);
        note(g === e, m);
    endtask
    task automatic cmp_cnt(input logic [15:0] g, input logic [15:0] e);
        note(g === e, "count differs");
    endtask
    // Strobe is read while settled, before the edge that uses it
    task automatic wait_strobe();
        logic e;
        int k;
        k = 0;
        do begin
            e = bit_en;
            @(posedge i_clk);
            #1;
            k++;
        end while (e !== 1'b1 && k < 8);
        if (e !== 1'b1) hang("no bit strobe");
    endtask
    // Payload of n octets with a special octet every fifth place
    task automatic make(input int n, input logic [7:0] spec);
        pl.delete();
        for (int i = 0; i < n; i++) begin
            pl.push_back(i % 5 == 0 ? spec : 8'($random(seed)));
        end
    endtask
    // Push a packet, holding each octet until ready is seen
    task automatic send_pkt();
        int k;
        logic r;
        for (int i = 0; i < pl.size(); i++) begin
            tx = {1'b1, i == pl.size() - 1, pl[i]};
            k = 0;
            do begin
                r = tx_ready;
                @(posedge i_clk);
                #1;
                k++;
            end while (r !== 1'b1 && k < 2000);
            if (r !== 1'b1) hang("push refused");
        end
        tx = '0;
    endtask
    // Loop one frame back and check the outcome
    task automatic run(input logic bad, input logic [15:0] dbad,
        input logic chk);
        int n0;
        logic [15:0] b0, a0;
        n0 = eops;
        b0 = bad_cnt;
        a0 = abort_cnt;
        rxq.delete();
        send_pkt();
        for (int k = 0; k < 30000 && eops == n0; k++) @(posedge i_clk);
        if (eops == n0) hang("no frame end");
        repeat (4) @(posedge i_clk);
        #1;
        cmp_flag(last_bad, bad, "discard mark differs");
        cmp_cnt(bad_cnt, b0 + dbad);
        cmp_cnt(abort_cnt, a0);
        if (chk) begin
            cmp_cnt(16'(rxq.size()), 16'(pl.size()));
            foreach (pl[i]) cmp_oct(rxq[i], pl[i]);
        end
    endtask
    // Raw line octets, first octet in the low bits; a reset first drops
    // octet sync, since injected bits need not match the looped phase
    task automatic inject(input logic [63:0] w);
        logic [15:0] a0;
        inj_en = 1'b1;
        inj_bit = 1'b0;
        i_rst_n = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        a0 = abort_cnt;
        wait_strobe();
        rxq.delete();
        for (int i = 0; i < 64; i++) begin
            inj_bit = w[i];
            wait_strobe();
        end
        repeat (20) @(posedge i_clk);
        #1;
        cmp_cnt(abort_cnt, a0 + 16'h0001);
        cmp_flag(last_bad, 1'b1, "abort not discarded");
        cmp_cnt(16'(rxq.size()), 16'h0000);
        inj_en = 1'b0;
    endtask
    task automatic fill_chk(input logic b);
        repeat (16) wait_strobe();
        repeat (24) begin
            wait_strobe();
            cmp_flag(tx_bit, b, "fill bit differs");
        end
    endtask

    initial begin
        cfg = '0;
        tx = '0;
        {slow, inj_en, inj_bit} = 3'h0;
        cfg.tx_fcs_en = 1'b1;
        cfg.rx_fcs_en = 1'b1;
        cfg.fill = HLE_FLAG;
        cfg.len_min = HLE_LEN_MIN;
        cfg.len_max = HLE_LEN_MAX;
        {cfg.tx_addr, cfg.tx_ctrl, cfg.tx_sapi} = 32'h0403_0801;
        {cfg.rx_addr, cfg.rx_ctrl, cfg.rx_sapi} = 32'h0403_0801;
        repeat (10) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        make(62, 8'hFF);
        run(1'b0, 16'h0000, 1'b1);
        {cfg.fcs32, cfg.scr_en, slow} = 3'h7;
        make(64, HLE_FLAG);
        run(1'b0, 16'h0000, 1'b1);
        {cfg.fcs32, cfg.scr_en, cfg.fcs_corrupt} = 3'h1;
        make(62, 8'h3F);
        run(1'b1, 16'h0001, 1'b0);
        cfg.fcs_corrupt = 1'b0;
        make(61, 8'h3F);
        run(1'b1, 16'h0000, 1'b0);
        cfg.len_max = 11'h050;
        make(79, 8'hFF);
        run(1'b1, 16'h0000, 1'b0);
        make(78, 8'hFF);
        run(1'b0, 16'h0000, 1'b1);
        cfg.len_max = HLE_LEN_MAX;
        cfg.x86 = 1'b1;
        make(64, HLE_FLAG);
        run(1'b0, 16'h0000, 1'b1);
        make(64, HLE_ESC);
        run(1'b0, 16'h0000, 1'b1);
        cfg.rx_sapi = 16'h0802;
        run(1'b1, 16'h0000, 1'b0);
        cfg.rx_sapi = cfg.tx_sapi;
        cfg.rx_addr = 8'h05;
        run(1'b1, 16'h0000, 1'b0);
        cfg.rx_addr = cfg.tx_addr;
        cfg.x86 = 1'b0;
        for (int r = 0; r < 3; r++) begin
            {cfg.fcs32, cfg.scr_en, slow} = 3'($random(seed));
            make(62 + ($random(seed) & 31), 8'hFF);
            run(1'b0, 16'h0000, 1'b1);
        end
        cfg.x86 = 1'b1;
        inject(64'h7E7E_7E7D_DD7D_117E);
        cfg.x86 = 1'b0;
        inject(64'h7E7E_7E7E_FFA5_7E7E);
        i_ce = 1'b0;
        repeat (20) @(posedge i_clk);
        #1 i_ce = 1'b1;
        cfg.fill = 8'h00;
        fill_chk(1'b0);
        cfg.fill = 8'hFF;
        fill_chk(1'b1);
        cmp_flag(saw_full, 1'b1, "queue never filled");
        cmp_flag(tx_ready, 1'b1, "queue not drained");
        end_of_test();
    end
endmodule // hle_encap_bench
`default_nettype wire
